/* testbench/cpu_bus_model.sv */
`timescale 1ns/10ps
module cpu_bus_model (
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   // Requests from the bench; i_cmd bit 7 suppresses the bus cycle.
   input  wire logic        i_req,
   input  wire logic [7:0]  i_cmd,
   input  wire logic [15:0] i_word,
   // Bus activity toward the trace logic.
   output logic             o_match_a,
   output logic             o_match_b,
   output logic             o_data_match_b,
   output logic             o_addr_ge_a,
   output logic             o_addr_le_b,
   output logic             o_exec_a,
   output logic             o_exec_b,
   output logic             o_bus_valid,
   output logic [15:0]      o_word
);
   // Levels that are no longer qualified flip so a stale value is never seen.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {o_match_a, o_match_b, o_data_match_b, o_addr_ge_a, o_addr_le_b} <= 5'h00;
         {o_exec_a, o_exec_b, o_bus_valid} <= 3'h0;
         o_word <= 16'h0000;
      end else if (i_req) begin
         {o_match_a, o_match_b, o_data_match_b, o_addr_ge_a, o_addr_le_b} <= i_cmd[6:2];
         {o_exec_a, o_exec_b, o_bus_valid} <= {i_cmd[1:0], ~i_cmd[7]};
         o_word <= i_word;
      end else begin
         {o_match_a, o_match_b, o_exec_a, o_exec_b, o_bus_valid} <= 5'h00;
         {o_data_match_b, o_addr_ge_a, o_addr_le_b} <= ~{o_data_match_b, o_addr_ge_a, o_addr_le_b};
         o_word <= ~o_word;
      end
   end
endmodule : cpu_bus_model

/* testbench/dbg_trig_status_tb.sv */
`timescale 1ns/10ps
module dbg_trig_status_tb;
   import dbg_trig_pkg::*;
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        psel = 1'h0;
   logic        pen = 1'h0;
   logic        pwr = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        req = 1'h0;
   logic [7:0]  cmd = 8'h00;
   logic [15:0] word = 16'h0000;
   logic [31:0] prdata;
   logic        pready, pslverr, brk, ma, mb, mdb, ge, le, ea, eb, bv;
   logic [15:0] cw;
   logic [31:0] v;
   logic        err;
   int          miscompares = 0;
   int          checked = 0;
   int          breaks = 0;
   dbg_trig_status #(.DATA_W(16)) dut (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_match_a(ma), .i_match_b(mb), .i_data_match_b(mdb),
      .i_addr_ge_a(ge), .i_addr_le_b(le), .i_exec_a(ea), .i_exec_b(eb), .i_bus_valid(bv),
      .i_capture_word(cw), .o_break_req(brk));
   cpu_bus_model cpu (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_cmd(cmd), .i_word(word),
      .o_match_a(ma), .o_match_b(mb), .o_data_match_b(mdb), .o_addr_ge_a(ge),
      .o_addr_le_b(le), .o_exec_a(ea), .o_exec_b(eb), .o_bus_valid(bv), .o_word(cw));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (brk === 1'h1) breaks++;
   end
   task automatic test_done;
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {2'h2, wr, a, d};
      @(posedge clk);
      pen <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) begin
         miscompares++;
         test_done();
      end
      v = prdata;
      err = pslverr;
      {psel, pen} <= 2'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask : rd
   task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
      rd(OFS_TRACE_STATUS);
      check("trace_status", v & {24'h0, mask}, {24'h0, exp});
   endtask : stat
   task automatic cyc(input logic [7:0] c, input logic [15:0] w);
      @(posedge clk);
      {req, cmd, word} <= {1'h1, c, w};
      @(posedge clk);
      req <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : cyc
   task automatic s_regs;
      rd(OFS_TRIGGER_CONFIG);
      check("trigger_config", v, {24'h0, TRIG_CFG_RESET});
      wr(OFS_TRIGGER_CONFIG, 32'hFF);
      rd(OFS_TRIGGER_CONFIG);
      check("trigger_config", v, 32'hCF);
      wr(OFS_TRACE_STATUS, 32'hFF);
      stat(8'hFF, 8'h00);
      rd(8'h20);
      check("pslverr", {31'h0, err}, 32'h1);
   endtask : s_regs
   task automatic s_end;
      int b0;
      b0 = breaks;
      wr(OFS_TRIGGER_CONFIG, 32'h00);
      wr(OFS_TRACE_CONTROL, 32'hD0);
      for (int k = 1; k <= 10; k++) cyc(8'h00, {8'hA0, 8'(k)});
      stat(8'h20, 8'h20);
      cyc(8'hC0, 16'h0000);
      stat(8'hEF, 8'h88);
      wr(OFS_TRACE_STATUS, 32'h00);
      stat(8'hEF, 8'h88);
      check("break pulses", breaks - b0, 32'h1);
      for (int j = 0; j < 8; j++) begin
         rd(OFS_FIFO_HIGH);
         rd(OFS_FIFO_HIGH);
         check("fifo_high_byte", v, 32'hA0);
         rd(OFS_FIFO_LOW);
         check("fifo_low_byte", v, 32'(j + 3));
      end
      stat(8'h0F, 8'h08);
   endtask : s_end
   task automatic s_abort;
      int b0;
      b0 = breaks;
      wr(OFS_TRACE_CONTROL, 32'hD0);
      stat(8'hEF, 8'h20);
      wr(OFS_TRIGGER_CONFIG, 32'h07);
      rd(OFS_TRIGGER_CONFIG);
      check("trigger_config", v, 32'h00);
      wr(OFS_TRACE_CONTROL, 32'h90);
      stat(8'h20, 8'h00);
      wr(OFS_TRACE_CONTROL, 32'hD0);
      wr(OFS_TRACE_CONTROL, 32'h50);
      stat(8'h20, 8'h00);
      rd(OFS_TRACE_CONTROL);
      check("trace_control", v, 32'h10);
      check("break pulses", breaks - b0, 32'h0);
   endtask : s_abort
   task automatic s_begin;
      int b0;
      b0 = breaks;
      wr(OFS_TRIGGER_CONFIG, 32'h41);
      wr(OFS_TRACE_CONTROL, 32'hD0);
      for (int k = 0; k < 9; k++) cyc(8'h00, 16'h1111);
      stat(8'hEF, 8'h20);
      cyc(8'hA0, 16'h0000);
      for (int k = 0; k < 7; k++) cyc(8'h00, {8'hB0, 8'(k)});
      stat(8'h20, 8'h20);
      cyc(8'h00, 16'hB007);
      stat(8'hEF, 8'h48);
      check("break pulses", breaks - b0, 32'h1);
      rd(OFS_FIFO_HIGH);
      check("fifo_high_byte", v, 32'hB0);
   endtask : s_begin
   task automatic s_event;
      wr(OFS_TRIGGER_CONFIG, 32'h03);
      wr(OFS_TRACE_CONTROL, 32'hC0);
      for (int k = 1; k <= 8; k++) begin
         cyc(8'h00, 16'h0055);
         cyc(8'h20, {8'h00, 8'(k)});
      end
      stat(8'hEF, 8'h48);
      for (int j = 1; j <= 8; j++) begin
         rd(OFS_FIFO_LOW);
         check("fifo_low_byte", v, 32'(j));
      end
   endtask : s_event
   task automatic s_modes;
      logic [7:0] cfg [11] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h80,
                               8'h09, 8'h0F, 8'h04};
      logic [7:0] c1 [11] = '{8'h20, 8'h00, 8'h40, 8'h40, 8'h50, 8'h08, 8'h0C, 8'h40,
                              8'h40, 8'h7F, 8'h20};
      logic [7:0] c2 [11] = '{8'h40, 8'h20, 8'h20, 8'h50, 8'h40, 8'h0C, 8'h08, 8'h42,
                              8'h60, 8'h0C, 8'h40};
      logic [10:0] e2 = 11'h700;
      for (int i = 0; i < 11; i++) begin
         wr(OFS_TRIGGER_CONFIG, {24'h0, cfg[i]});
         wr(OFS_TRACE_CONTROL, 32'hC0);
         cyc(c1[i], 16'h0000);
         stat(8'h20, 8'h20);
         cyc(c2[i], 16'h0000);
         stat(8'h20, {2'h0, e2[i], 5'h00});
         wr(OFS_TRACE_CONTROL, 32'h00);
      end
   endtask : s_modes
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'h1;
      s_regs();
      s_end();
      s_abort();
      s_begin();
      s_event();
      s_modes();
      test_done();
   end
endmodule : dbg_trig_status_tb

/* verilog/dbg_trig_pkg.sv */
package dbg_trig_pkg;
   // Byte addresses of the APB register words.
   localparam logic [7:0] OFS_TRACE_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_TRIGGER_CONFIG = 8'h04;
   localparam logic [7:0] OFS_TRACE_STATUS   = 8'h08;
   localparam logic [7:0] OFS_FIFO_LOW       = 8'h0C;
   localparam logic [7:0] OFS_FIFO_HIGH      = 8'h10;
   localparam int         ADDR_W             = 8;
   // Trace control fields.
   localparam int BIT_MODULE_ENABLE = 7;
   localparam int BIT_ARM           = 6;
   localparam int BIT_BREAK_EN      = 4;
   // Trigger config fields.
   localparam int BIT_TYPE_SEL      = 7;
   localparam int BIT_BEGIN_SEL     = 6;
   localparam logic [7:0] TRIG_CFG_WMASK = 8'hCF;
   localparam logic [7:0] TRIG_CFG_RESET = 8'h00;
   // Trace status fields.
   localparam int BIT_MATCH_A = 7;
   localparam int BIT_MATCH_B = 6;
   localparam int BIT_ARM_STATUS_FLAG    = 5;
   localparam int FIFO_DEPTH  = 8;
   localparam int CNT_W       = 4;
   localparam int PTR_W       = 3;
   typedef enum logic [3:0] {
      MODE_A_ONLY   = 4'h0,
      MODE_A_OR_B   = 4'h1,
      MODE_A_THEN_B = 4'h2,
      MODE_EV_B     = 4'h3,
      MODE_A_EV_B   = 4'h4,
      MODE_A_AND_B  = 4'h5,
      MODE_A_NOT_B  = 4'h6,
      MODE_INSIDE   = 4'h7,
      MODE_OUTSIDE  = 4'h8
   } trig_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ARMED  = 3'b010,
      ST_SECOND = 3'b100
   } run_state_t;
endpackage : dbg_trig_pkg

/* verilog/dbg_trig_status.sv */
// What this block does
// - Trigger config readable always, writable only while disarmed, bits 4-5 read zero.
// - Type bit set qualifies matches by opcode execution; clear triggers on access.
// - Begin select 0 stores until trigger ends capture; 1 trigger starts storage.
// - Event-only modes ignore begin select and always run as begin trace.
// - Mode 0 is A only, 1 is A or B, 2 is A then B.
// - Mode 3 stores on every B event; mode 4 waits A then stores on B.
// - Mode 5 needs A address and B data; mode 6 A and not B data.
// - Mode 7 triggers inside range A..B; mode 8 outside it.
// - Mode codes 9 through 15 never trigger.
// - Trace status is read-only; writes change nothing.
// - Match A flag clears at run start, sets on A match after arming.
// - Match B flag clears at run start, sets on B match after arming.
// - Arm status mirrors arm control while enabled; writing arm together with enable sets it.
// - Run ends by itself: begin trace at FIFO full, end trace at trigger.
// - Writing zero to arm or enable stops an active run at once.
// - Valid count clears at run start and shows valid words, 0 to 8.
// - Valid count does not decrement while FIFO words are read.
// - With breaks enabled, end trace breaks at trigger, begin trace at full.
// - Reading the low FIFO byte while no run is active advances the FIFO; high byte does not.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module dbg_trig_status #(
   parameter int DATA_W = 16
) (
   // Clock and reset.
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_rst_b,
   // APB slave.
   input  wire logic                           i_psel,
   input  wire logic                           i_penable,
   input  wire logic                           i_pwrite,
   input  wire logic [dbg_trig_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]                    i_pwdata,
   output logic      [31:0]                    o_prdata,
   output logic                                o_pready,
   output logic                                o_pslverr,
   // Comparator matches: A and B are one-cycle pulses per bus access; data and range compares are levels.
   input  wire logic                           i_match_a,
   input  wire logic                           i_match_b,
   input  wire logic                           i_data_match_b,
   input  wire logic                           i_addr_ge_a,
   input  wire logic                           i_addr_le_b,
   // Opcode tracking: executed matches and capture word.
   input  wire logic                           i_exec_a,
   input  wire logic                           i_exec_b,
   input  wire logic                           i_bus_valid,
   input  wire logic [DATA_W-1:0]              i_capture_word,
   // CPU break request.
   output logic                                o_break_req
);
   import dbg_trig_pkg::*;

   logic [7:0]        trace_control;
   logic [7:0]        trigger_config;
   logic              match_a_flag;
   logic              match_b_flag;
   logic [CNT_W-1:0]  fifo_valid_count;
   logic [PTR_W-1:0]  wr_ptr;
   logic [PTR_W-1:0]  rd_ptr;
   logic              storing;
   logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
   run_state_t        state;
   run_state_t        next_state;

   wire module_enable  = trace_control[BIT_MODULE_ENABLE];
   wire arm_ctl        = trace_control[BIT_ARM];
   wire armed          = state != ST_IDLE;
   wire wr_acc         = i_psel & i_penable & i_pwrite;
   wire rd_acc         = i_psel & i_penable & ~i_pwrite;
   wire sel_ctl        = i_paddr == OFS_TRACE_CONTROL;
   wire sel_cfg        = i_paddr == OFS_TRIGGER_CONFIG;
   wire sel_sts        = i_paddr == OFS_TRACE_STATUS;
   wire sel_flo        = i_paddr == OFS_FIFO_LOW;
   wire sel_fhi        = i_paddr == OFS_FIFO_HIGH;
   wire mapped         = sel_ctl | sel_cfg | sel_sts | sel_flo | sel_fhi;
   wire ctl_wr         = wr_acc & sel_ctl;
   wire [7:0] ctl_wdata = i_pwdata[7:0];
   wire start_run      = ctl_wr & ctl_wdata[BIT_MODULE_ENABLE] & ctl_wdata[BIT_ARM] & ~armed;
   wire manual_stop    = ctl_wr & armed
                         & ~(ctl_wdata[BIT_MODULE_ENABLE] & ctl_wdata[BIT_ARM]);

   wire [3:0] mode     = trigger_config[3:0];
   wire qa             = trigger_config[BIT_TYPE_SEL] ? i_exec_a : i_match_a;
   wire qb             = trigger_config[BIT_TYPE_SEL] ? i_exec_b : i_match_b;
   wire event_only     = (mode == MODE_EV_B) | (mode == MODE_A_EV_B);
   wire begin_trace    = event_only | trigger_config[BIT_BEGIN_SEL];

   // Mode decode: trigger from the first stage and from the second.
   function automatic logic first_hit(input logic [3:0] m, input logic a, input logic b,
                                      input logic db, input logic ge, input logic le);
      case (m)
         MODE_A_ONLY:   first_hit = a;
         MODE_A_OR_B:   first_hit = a | b;
         MODE_A_THEN_B: first_hit = a;
         MODE_EV_B:     first_hit = b;
         MODE_A_EV_B:   first_hit = a;
         MODE_A_AND_B:  first_hit = a & db;
         MODE_A_NOT_B:  first_hit = a & ~db;
         MODE_INSIDE:   first_hit = ge & le;
         MODE_OUTSIDE:  first_hit = ~ge | ~le;
         default:       first_hit = 1'b0;
      endcase
   endfunction : first_hit

   wire addr_seen      = i_bus_valid;
   wire hit1           = first_hit(mode, qa, qb, i_data_match_b,
                                   i_addr_ge_a & addr_seen, i_addr_le_b & addr_seen)
                         & ((mode != MODE_INSIDE && mode != MODE_OUTSIDE) || addr_seen);
   wire two_stage      = (mode == MODE_A_THEN_B) | (mode == MODE_A_EV_B);
   wire trig_event     = (state == ST_ARMED) ? (hit1 & ~two_stage)
                         : (state == ST_SECOND) ? qb : 1'b0;
   wire to_second      = (state == ST_ARMED) & hit1 & two_stage;

   // event-only storage happens per B event; others per bus cycle.
   wire ev_store       = event_only & trig_event;
   wire cyc_store      = ~event_only & i_bus_valid & (storing | trig_event & begin_trace);
   wire store_now      = armed & (ev_store | cyc_store) & ~manual_stop;
   wire full_now       = fifo_valid_count == CNT_W'(FIFO_DEPTH);
   wire will_fill      = store_now & begin_trace & (fifo_valid_count == CNT_W'(FIFO_DEPTH - 1));
   wire run_end        = armed & ~manual_stop
                         & (begin_trace ? will_fill : (trig_event & ~begin_trace));
   wire stop_any       = run_end | manual_stop;
   wire fifo_adv       = rd_acc & sel_flo & ~armed;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:   if (start_run) next_state = ST_ARMED;
         ST_ARMED:  if (stop_any) next_state = ST_IDLE;
                    else if (to_second) next_state = ST_SECOND;
         ST_SECOND: if (stop_any) next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // arm bit cleared by run end; a stop clears it too.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trace_control <= 8'h00;
      end else if (ctl_wr) begin
         trace_control <= ctl_wdata & {1'b1, start_run | (armed & ~stop_any), 6'h3F};
      end else if (run_end) begin
         trace_control[BIT_ARM] <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trigger_config <= TRIG_CFG_RESET;
      end else if (wr_acc && sel_cfg && !arm_ctl) begin
         trigger_config <= i_pwdata[7:0] & TRIG_CFG_WMASK;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         match_a_flag <= 1'b0;
      end else if (start_run) begin
         match_a_flag <= 1'b0;
      end else if (armed && qa) begin
         match_a_flag <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         match_b_flag <= 1'b0;
      end else if (start_run) begin
         match_b_flag <= 1'b0;
      end else if (armed && qb) begin
         match_b_flag <= 1'b1;
      end
   end

   // count clears at start; reads leave it alone.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fifo_valid_count <= '0;
      end else if (start_run) begin
         fifo_valid_count <= '0;
      end else if (store_now && !full_now) begin
         fifo_valid_count <= fifo_valid_count + CNT_W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         storing <= 1'b0;
      end else if (start_run || stop_any) begin
         storing <= start_run & ~begin_trace;
      end else if (armed && trig_event && begin_trace) begin
         storing <= 1'b1;
      end
   end

   // circular write pointer overwrites the oldest word.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (start_run) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (store_now) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
         end
         if (run_end && !begin_trace) begin
            rd_ptr <= full_now ? wr_ptr + PTR_W'(store_now) : '0;
         end else if (fifo_adv) begin
            rd_ptr <= rd_ptr + PTR_W'(1);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < FIFO_DEPTH; g++) begin : g_fifo
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               fifo_mem[g] <= '0;
            end else if (store_now && wr_ptr == PTR_W'(g)) begin
               fifo_mem[g] <= i_capture_word;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_break_req <= 1'b0;
      end else begin
         o_break_req <= run_end & trace_control[BIT_BREAK_EN];
      end
   end

   // arm status mirror; status built only from state.
   wire        arm_status_flag = module_enable & arm_ctl;
   wire [7:0]  status_byte = {match_a_flag, match_b_flag, arm_status_flag, 1'b0,
                              fifo_valid_count};
   wire [15:0] head_word   = 16'(fifo_mem[rd_ptr]);
   wire [7:0]  rd_mux = sel_ctl ? trace_control :
                        sel_cfg ? trigger_config :
                        sel_sts ? status_byte :
                        sel_flo ? head_word[7:0] :
                        sel_fhi ? head_word[15:8] : 8'h00;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= {24'h00_0000, rd_mux};
      end
   end

   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;

   cfg_reserved_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      trigger_config[5:4] == 2'b00)
      else $error("trigger config reserved bits set");
   cfg_locked_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      wr_acc && sel_cfg && arm_ctl |=> $stable(trigger_config))
      else $error("trigger config changed while armed");
   no_trig_rsv_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      mode > 4'h8 |-> !trig_event)
      else $error("reserved mode triggered");
   arm_mirror_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      start_run |=> arm_status_flag && armed)
      else $error("arm status not set on arm");
   stop_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      manual_stop |=> !armed && !arm_status_flag && !arm_ctl)
      else $error("run not stopped");
   end_trace_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      armed && !begin_trace && trig_event && !manual_stop |=> !armed)
      else $error("end trace did not stop");
   cnt_limit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      fifo_valid_count <= CNT_W'(FIFO_DEPTH))
      else $error("valid count above depth");
   cnt_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !start_run |=> fifo_valid_count >= $past(fifo_valid_count))
      else $error("valid count decremented");
   flag_clr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      start_run |=> !match_a_flag && !match_b_flag && fifo_valid_count == '0)
      else $error("start did not clear status");
   cfg_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      wr_acc && sel_cfg && !arm_ctl |=> trigger_config == ($past(i_pwdata[7:0]) & TRIG_CFG_WMASK))
      else $error("trigger config write lost");
   type_qual_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      trigger_config[BIT_TYPE_SEL] && state == ST_ARMED && mode == MODE_A_ONLY && !i_exec_a
      |-> !trig_event)
      else $error("unexecuted match triggered");
   end_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      armed && !begin_trace && i_bus_valid && !manual_stop |-> store_now)
      else $error("end trace missed a bus cycle");
   event_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      armed && event_only && !trig_event |-> !store_now)
      else $error("event mode stored without event");
   a_or_b_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      state == ST_ARMED && mode == MODE_A_OR_B && (qa || qb) |-> trig_event)
      else $error("A or B mode missed a match");
   full_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      state == ST_ARMED && mode == MODE_A_AND_B && !i_data_match_b |-> !trig_event)
      else $error("full mode triggered without data");
   range_in_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      state == ST_ARMED && mode == MODE_INSIDE && i_bus_valid && i_addr_ge_a && i_addr_le_b
      |-> trig_event)
      else $error("inside range missed");
   status_ro_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      wr_acc && sel_sts && !armed |=> $stable(status_byte))
      else $error("status changed by a write");
   match_a_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      armed && qa |=> match_a_flag)
      else $error("match A flag not set");
   match_b_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      armed && qb |=> match_b_flag)
      else $error("match B flag not set");
   begin_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      begin_trace && will_fill && !manual_stop |=> !armed && fifo_valid_count == CNT_W'(FIFO_DEPTH))
      else $error("begin trace did not stop when full");
   break_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      run_end && trace_control[BIT_BREAK_EN] |=> o_break_req)
      else $error("break request missing");
   break_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !run_end |=> !o_break_req)
      else $error("break request without run end");
   fifo_adv_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      rd_acc && sel_flo && !armed |=> rd_ptr == $past(rd_ptr) + PTR_W'(1))
      else $error("low byte read did not advance");
   fifo_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      rd_acc && sel_fhi && !armed |=> $stable(rd_ptr))
      else $error("high byte read moved the FIFO");
   oldest_ptr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      run_end && !begin_trace && full_now && !store_now |=> rd_ptr == $past(wr_ptr))
      else $error("read pointer not at oldest word");
endmodule : dbg_trig_status
